/* hdl/atci_defs.vh */
`ifndef ATCI_DEFS_VH
`define ATCI_DEFS_VH

// ==========================================================
// Timing
`define ATCI_CLK_HZ       64'd200_000_000
`define ATCI_IDLE_MIN     64'd15
`define ATCI_SEC_PER_MIN  64'd60

// ==========================================================
// Character codes
`define ATCI_CH_CR        8'h0D
`define ATCI_CH_XON       8'h11
`define ATCI_CH_XOFF      8'h13
`define ATCI_CH_SPACE     8'h20
`define ATCI_CH_DOT       8'h2E
`define ATCI_CH_ZERO      8'h30
`define ATCI_CH_NINE      8'h39
`define ATCI_CH_LO_A      8'h61
`define ATCI_CH_LO_Z      8'h7A
`define ATCI_CH_TILDE     8'h7E
`define ATCI_CH_DEL       8'h7F
`define ATCI_CASE_GAP     8'h20

// ==========================================================
// Command words, upper case, right justified
`define ATCI_W_STATUS     56'h0053_5441_5455_53
`define ATCI_W_VALUES     56'h0056_414C_5545_53
`define ATCI_W_MODEL      56'h0000_4D4F_4445_4C
`define ATCI_W_EVENTS     56'h0045_5645_4E54_53
`define ATCI_W_SETGRP     56'h5348_4F57_5345_54
`define ATCI_W_STNLINE    56'h5354_4C49_4E49_44
`define ATCI_W_FAULT      56'h0000_4641_554C_54
`define ATCI_W_FLTSTAT    56'h4653_5441_5455_53
`define ATCI_W_LOGIN      56'h0000_4C4F_4749_4E
`define ATCI_W_LOGOUT     56'h004C_4F47_4F55_54
`define ATCI_W_HELP       56'h0000_0048_454C_50
`define ATCI_WORD_MAX     5'h07

// ==========================================================
// Command codes; all but LOGIN are dispatched
`define ATCI_C_STATUS     4'h0
`define ATCI_C_VALUES     4'h1
`define ATCI_C_MODEL      4'h2
`define ATCI_C_EVENTS     4'h3
`define ATCI_C_SETGRP     4'h4
`define ATCI_C_STNLINE    4'h5
`define ATCI_C_FAULT      4'h6
`define ATCI_C_FLTSTAT    4'h7
`define ATCI_C_LOGIN      4'h8
`define ATCI_C_LOGOUT     4'h9
`define ATCI_C_HELP       4'hA

// ==========================================================
// Messages
`define ATCI_M_TYPELOGIN  4'h0
`define ATCI_M_PWPROMPT   4'h1
`define ATCI_M_LOGGEDIN   4'h2
`define ATCI_M_BADPW      4'h3
`define ATCI_M_UNKNOWN    4'h4
`define ATCI_M_GRPPROMPT  4'h5
`define ATCI_M_FLTPROMPT  4'h6
`define ATCI_MSG_TOP      6'h37

// ==========================================================
// Parameter limits
`define ATCI_GRP_MIN      8'h01
`define ATCI_GRP_MAX      8'h04
`define ATCI_PAR_DIGITS   2'h3

`endif

/* hdl/atci_msg_rom.v */
`timescale 1ns/1ps
`include "atci_defs.vh"

module atci_msg_rom (
   // Clock and reset
   input  wire       core_clk,
   input  wire       sys_rst,
   // Lookup
   input  wire [3:0] msg_sel,
   input  wire [5:0] char_idx,
   output reg  [7:0] rom_char_q
);

   // ==========================================================
   // Message text
   // Strings are left padded with zero bytes; the reader skips them.
   // Only printable text plus CR LF: a plain teletype suffices. [RULE5]
   reg [447:0] text;

   always @* begin
      case (msg_sel)
         `ATCI_M_TYPELOGIN : text = "\015\nType login.\015\n";
         `ATCI_M_PWPROMPT  : text = "\015\nEnter password.\015\n";
         `ATCI_M_LOGGEDIN  : text = "\015\nLogged in.\015\n";
         `ATCI_M_BADPW     : text = "\015\nBad Password.\015\n";
         `ATCI_M_UNKNOWN   :
            text = "\015\nUnknown command, type \"help\" for list of commands.\015\n";
         `ATCI_M_GRPPROMPT : text = "\015\nEnter setting group (1-4) - ";
         `ATCI_M_FLTPROMPT : text = "\015\nEnter fault number - ";
         default           : text = 448'h0;
      endcase
   end

   // ==========================================================
   // Registered read
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rom_char_q <= 8'h00;
      end else begin
         rom_char_q <= text[8*char_idx +: 8];
      end
   end

endmodule // atci_msg_rom

/* hdl/atci_core.v */
`timescale 1ns/1ps
`include "atci_defs.vh"

// How it works
// RULE1 - Echo every printable character as received
// RULE2 - Delete removes last character of the line
// RULE3 - Letter case folded before matching
// RULE4 - Drop controls; XON/XOFF resume/pause transmit
// RULE5 - Only plain text and CR LF sent
// RULE6 - Logged out: only login sequence acted on
// RULE7 - Only the stored view password accepted
// RULE8 - CR prompts login; login word prompts password
// RULE9 - Password characters echoed as periods
// RULE10 - Report logged in or bad password
// RULE11 - Eleven commands recognised, ten dispatched; login is never dispatched, it prompts for the password instead
// RULE12 - Group and fault take inline parameter
// RULE13 - Missing parameter prompts; group range 1-4
// RULE14 - Unknown command answered with help hint
// RULE15 - Logout ends the session
// RULE16 - Auto logout after 15 idle minutes
// RULE17 - Terminal matches configured port settings
// RULE18 - Carriage return ends and executes line

module atci_core #(
   parameter        PW_MAX      = 8,
   parameter [63:0] IDLE_CYCLES = `ATCI_IDLE_MIN * `ATCI_SEC_PER_MIN * `ATCI_CLK_HZ
) (
   // Clock and reset
   input  wire                  core_clk,
   input  wire                  sys_rst,
   // Received characters
   input  wire                  rx_valid,
   input  wire [7:0]            rx_data,
   // Transmitted characters
   input  wire                  tx_ready,
   output reg                   tx_valid_q,
   output reg  [7:0]            tx_data_q,
   // Stored view password
   input  wire [8*PW_MAX-1:0]   view_pw,
   input  wire [4:0]            view_pw_len,
   // Command dispatch
   output reg                   cmd_valid_q,
   output reg  [3:0]            cmd_code_q,
   output reg  [7:0]            cmd_param_q,
   output reg                   logged_in_q
);

   localparam [1:0] MODE_OUT   = 2'd0;
   localparam [1:0] MODE_PW    = 2'd1;
   localparam [1:0] MODE_CMD   = 2'd2;
   localparam [1:0] MODE_PARAM = 2'd3;
   localparam [4:0] PW_LIM     = PW_MAX;

   reg  [1:0]          mode_q;
   reg  [55:0]         word_q;
   reg  [4:0]          wlen_q;
   reg                 sp_q;
   reg  [7:0]          par_q;
   reg  [1:0]          pcnt_q;
   reg                 pbad_q;
   reg  [8*PW_MAX-1:0] pwb_q;
   reg  [4:0]          plen_q;
   reg  [3:0]          pend_q;
   reg                 msg_go_q;
   reg  [3:0]          msg_sel_q;
   reg  [39:0]         idle_q;
   reg                 xoff_q;
   reg                 echo_pend_q;
   reg  [7:0]          echo_ch_q;
   reg                 msg_act_q;
   reg  [3:0]          rom_sel_q;
   reg  [5:0]          msg_idx_q;
   reg                 rom_ok_q;
   wire [7:0]          rom_char;

   // ==========================================================
   // Character classes
   wire        is_lower = (rx_data >= `ATCI_CH_LO_A) && (rx_data <= `ATCI_CH_LO_Z);
   wire [7:0]  ch_up    = is_lower ? (rx_data - `ATCI_CASE_GAP) : rx_data; // [RULE3]
   wire        is_print = (rx_data >= `ATCI_CH_SPACE) && (rx_data <= `ATCI_CH_TILDE);
   wire        is_cr    = (rx_data == `ATCI_CH_CR);
   wire        is_del   = (rx_data == `ATCI_CH_DEL);
   wire        is_digit = (rx_data >= `ATCI_CH_ZERO) && (rx_data <= `ATCI_CH_NINE);
   wire        is_space = (rx_data == `ATCI_CH_SPACE);
   // Input other than XON/XOFF arriving while an answer is still going out is dropped
   wire        busy     = msg_act_q | echo_pend_q | msg_go_q;
   wire        take     = rx_valid & ~busy;
   wire        echo_go  = take & is_print; // [RULE1]
   wire        tx_free  = ~tx_valid_q | tx_ready;
   wire [11:0] par_next = {4'h0, par_q} * 12'd10 + {8'h00, rx_data[3:0]};
   wire        logged   = (mode_q == MODE_CMD) || (mode_q == MODE_PARAM);

   // ==========================================================
   // Password check, case folded per byte
   wire [8*PW_MAX-1:0] pw_fold;
   genvar gi;
   generate
      for (gi = 0; gi < PW_MAX; gi = gi + 1) begin : g_fold
         wire [7:0] b = view_pw[8*gi +: 8];
         assign pw_fold[8*gi +: 8] =
            ((b >= `ATCI_CH_LO_A) && (b <= `ATCI_CH_LO_Z)) ? (b - `ATCI_CASE_GAP) : b;
      end
   endgenerate
   wire pw_match = (plen_q == view_pw_len) && (plen_q <= PW_LIM) &&
                   (pwb_q == pw_fold); // [RULE7]

   // ==========================================================
   // Command lookup
   reg       hit;
   reg [3:0] code;

   always @* begin
      hit  = 1'b1;
      code = `ATCI_C_STATUS;
      case (word_q) // [RULE11]
         `ATCI_W_STATUS  : code = `ATCI_C_STATUS;
         `ATCI_W_VALUES  : code = `ATCI_C_VALUES;
         `ATCI_W_MODEL   : code = `ATCI_C_MODEL;
         `ATCI_W_EVENTS  : code = `ATCI_C_EVENTS;
         `ATCI_W_SETGRP  : code = `ATCI_C_SETGRP;
         `ATCI_W_STNLINE : code = `ATCI_C_STNLINE;
         `ATCI_W_FAULT   : code = `ATCI_C_FAULT;
         `ATCI_W_FLTSTAT : code = `ATCI_C_FLTSTAT;
         `ATCI_W_LOGIN   : code = `ATCI_C_LOGIN;
         `ATCI_W_LOGOUT  : code = `ATCI_C_LOGOUT;
         `ATCI_W_HELP    : code = `ATCI_C_HELP;
         default         : hit = 1'b0;
      endcase
      if ((wlen_q == 5'd0) || (wlen_q > `ATCI_WORD_MAX)) begin
         hit = 1'b0;
      end
   end

   wire par_ok = (pcnt_q != 2'd0) && !pbad_q;
   wire grp_ok = par_ok && (par_q >= `ATCI_GRP_MIN) && (par_q <= `ATCI_GRP_MAX);

   // ==========================================================
   // Line editing, login and dispatch
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_q      <= MODE_OUT;
         word_q      <= 56'h0;
         wlen_q      <= 5'd0;
         sp_q        <= 1'b0;
         par_q       <= 8'h00;
         pcnt_q      <= 2'd0;
         pbad_q      <= 1'b0;
         pwb_q       <= {8*PW_MAX{1'b0}};
         plen_q      <= 5'd0;
         pend_q      <= `ATCI_C_STATUS;
         msg_go_q    <= 1'b0;
         msg_sel_q   <= `ATCI_M_TYPELOGIN;
         idle_q      <= 40'h0;
         cmd_valid_q <= 1'b0;
         cmd_code_q  <= `ATCI_C_STATUS;
         cmd_param_q <= 8'h00;
         logged_in_q <= 1'b0;
      end else begin
         msg_go_q    <= 1'b0;
         cmd_valid_q <= 1'b0;
         // Any received byte counts as activity
         if (rx_valid || !logged) begin
            idle_q <= 40'h0;
         end else if (idle_q == IDLE_CYCLES[39:0] - 40'd1) begin
            idle_q      <= 40'h0;
            mode_q      <= MODE_OUT; // [RULE16]
            logged_in_q <= 1'b0;
         end else begin
            idle_q <= idle_q + 40'd1;
         end

         if (take && is_cr) begin // [RULE18]
            word_q <= 56'h0;
            wlen_q <= 5'd0;
            sp_q   <= 1'b0;
            par_q  <= 8'h00;
            pcnt_q <= 2'd0;
            pbad_q <= 1'b0;
            pwb_q  <= {8*PW_MAX{1'b0}};
            plen_q <= 5'd0;
            case (mode_q)
               MODE_OUT : begin
                  msg_go_q <= 1'b1; // [RULE6]
                  if (hit && (code == `ATCI_C_LOGIN) && !sp_q) begin
                     mode_q    <= MODE_PW; // [RULE8]
                     msg_sel_q <= `ATCI_M_PWPROMPT;
                  end else begin
                     msg_sel_q <= `ATCI_M_TYPELOGIN; // [RULE8]
                  end
               end
               MODE_PW : begin
                  msg_go_q <= 1'b1;
                  if (pw_match) begin
                     mode_q      <= MODE_CMD; // [RULE10]
                     logged_in_q <= 1'b1;
                     msg_sel_q   <= `ATCI_M_LOGGEDIN;
                  end else begin
                     mode_q    <= MODE_OUT; // [RULE10]
                     msg_sel_q <= `ATCI_M_BADPW;
                  end
               end
               MODE_CMD : begin
                  if (!hit && (wlen_q != 5'd0)) begin
                     msg_go_q  <= 1'b1; // [RULE14]
                     msg_sel_q <= `ATCI_M_UNKNOWN;
                  end else if (hit && (code == `ATCI_C_LOGIN)) begin
                     mode_q      <= MODE_PW;
                     logged_in_q <= 1'b0;
                     msg_go_q    <= 1'b1;
                     msg_sel_q   <= `ATCI_M_PWPROMPT;
                  end else if (hit && (code == `ATCI_C_SETGRP) && !grp_ok) begin
                     pend_q    <= code; // [RULE13]
                     mode_q    <= MODE_PARAM;
                     sp_q      <= 1'b1;
                     msg_go_q  <= 1'b1;
                     msg_sel_q <= `ATCI_M_GRPPROMPT;
                  end else if (hit && (code == `ATCI_C_FAULT) && !par_ok) begin
                     pend_q    <= code; // [RULE13]
                     mode_q    <= MODE_PARAM;
                     sp_q      <= 1'b1;
                     msg_go_q  <= 1'b1;
                     msg_sel_q <= `ATCI_M_FLTPROMPT;
                  end else if (hit) begin
                     cmd_valid_q <= 1'b1; // [RULE11] [RULE12]
                     cmd_code_q  <= code;
                     cmd_param_q <= par_q;
                     if (code == `ATCI_C_LOGOUT) begin
                        mode_q      <= MODE_OUT; // [RULE15]
                        logged_in_q <= 1'b0;
                     end
                  end
               end
               MODE_PARAM : begin
                  if ((pend_q == `ATCI_C_SETGRP) ? grp_ok : par_ok) begin
                     cmd_valid_q <= 1'b1;
                     cmd_code_q  <= pend_q;
                     cmd_param_q <= par_q;
                     mode_q      <= MODE_CMD;
                  end else begin
                     sp_q      <= 1'b1; // [RULE13]
                     msg_go_q  <= 1'b1;
                     msg_sel_q <= (pend_q == `ATCI_C_SETGRP) ?
                                  `ATCI_M_GRPPROMPT : `ATCI_M_FLTPROMPT;
                  end
               end
               default : mode_q <= MODE_OUT;
            endcase
         end else if (take && is_del) begin
            if (mode_q == MODE_PW) begin
               if (plen_q != 5'd0) begin
                  plen_q <= plen_q - 5'd1; // [RULE2]
                  if (plen_q <= PW_LIM) begin
                     pwb_q <= pwb_q >> 8;
                  end
               end
            end else if (sp_q) begin
               if (pcnt_q != 2'd0) begin
                  par_q  <= par_q / 8'd10; // [RULE2]
                  pcnt_q <= pcnt_q - 2'd1;
               end else if (mode_q != MODE_PARAM) begin
                  sp_q <= 1'b0;
               end
            end else if (wlen_q != 5'd0) begin
               wlen_q <= wlen_q - 5'd1; // [RULE2]
               if (wlen_q <= `ATCI_WORD_MAX) begin
                  word_q <= word_q >> 8;
               end
            end
         end else if (take && is_print) begin
            if (mode_q == MODE_PW) begin
               if (plen_q != 5'h1F) begin
                  plen_q <= plen_q + 5'd1;
               end
               if (plen_q < PW_LIM) begin
                  pwb_q <= {pwb_q[8*PW_MAX-9:0], ch_up}; // [RULE3]
               end
            end else if (sp_q) begin
               if (is_digit && (pcnt_q != `ATCI_PAR_DIGITS)) begin
                  pcnt_q <= pcnt_q + 2'd1; // [RULE12]
                  if (par_next > 12'd255) begin
                     pbad_q <= 1'b1;
                  end else begin
                     par_q <= par_next[7:0];
                  end
               end else if (!(is_space && (pcnt_q == 2'd0))) begin
                  pbad_q <= 1'b1;
               end
            end else if (is_space) begin
               if (wlen_q != 5'd0) begin
                  sp_q <= 1'b1; // [RULE12]
               end
            end else begin
               if (wlen_q != 5'h1F) begin
                  wlen_q <= wlen_q + 5'd1;
               end
               if (wlen_q < `ATCI_WORD_MAX) begin
                  word_q <= {word_q[47:0], ch_up}; // [RULE3]
               end
            end
         end
      end
   end

   // ==========================================================
   // Transmit: echo, messages, flow control
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         xoff_q      <= 1'b0;
         echo_pend_q <= 1'b0;
         echo_ch_q   <= 8'h00;
         tx_valid_q  <= 1'b0;
         tx_data_q   <= 8'h00;
         msg_act_q   <= 1'b0;
         rom_sel_q   <= `ATCI_M_TYPELOGIN;
         msg_idx_q   <= 6'd0;
         rom_ok_q    <= 1'b0;
      end else begin
         // Flow control acts even while busy; other controls fall through
         if (rx_valid && (rx_data == `ATCI_CH_XOFF)) begin
            xoff_q <= 1'b1; // [RULE4]
         end else if (rx_valid && (rx_data == `ATCI_CH_XON)) begin
            xoff_q <= 1'b0; // [RULE4]
         end
         if (tx_valid_q && tx_ready) begin
            tx_valid_q <= 1'b0;
         end
         if (echo_go) begin
            echo_pend_q <= 1'b1;
            echo_ch_q   <= (mode_q == MODE_PW) ? `ATCI_CH_DOT : rx_data; // [RULE9]
         end else if (echo_pend_q && tx_free && !xoff_q) begin
            tx_valid_q  <= 1'b1; // [RULE1]
            tx_data_q   <= echo_ch_q;
            echo_pend_q <= 1'b0;
         end
         // Registered ROM: one idle cycle after each index change
         if (msg_go_q) begin
            msg_act_q <= 1'b1;
            rom_sel_q <= msg_sel_q;
            msg_idx_q <= `ATCI_MSG_TOP;
            rom_ok_q  <= 1'b0;
         end else if (msg_act_q && !rom_ok_q) begin
            rom_ok_q <= 1'b1;
         end else if (msg_act_q) begin
            if ((rom_char == 8'h00) || (tx_free && !xoff_q && !echo_pend_q)) begin
               if (rom_char != 8'h00) begin
                  tx_valid_q <= 1'b1; // [RULE5]
                  tx_data_q  <= rom_char;
               end
               rom_ok_q <= 1'b0;
               if (msg_idx_q == 6'd0) begin
                  msg_act_q <= 1'b0;
               end else begin
                  msg_idx_q <= msg_idx_q - 6'd1;
               end
            end
         end
      end
   end

   atci_msg_rom u_rom (
      .core_clk   (core_clk),
      .sys_rst    (sys_rst),
      .msg_sel    (rom_sel_q),
      .char_idx   (msg_idx_q),
      .rom_char_q (rom_char)
   );

endmodule // atci_core

/* sim/atci_term_model.sv */
`timescale 1ns/1ps

// ==========
// Terminal side: logs every byte it accepts
module atci_term_model (
   // Clock and reset
   input  wire        core_clk,
   input  wire        sys_rst,
   // Stall pattern select
   input  wire        slow,
   // Byte stream from the block
   input  wire        tx_valid_q,
   input  wire  [7:0] tx_data_q,
   output logic       tx_ready
);
   logic [7:0] log_q [0:2047];
   logic [1:0] ph_q;
   int         n_rx;

   // Slow mode accepts one byte in four cycles, like a loaded link
   assign tx_ready = !slow || (ph_q == 2'h3);

   // Raw TTY capture, nothing interpreted
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ph_q <= 2'h0;
         n_rx <= 0;
      end else begin
         ph_q <= ph_q + 2'h1;
         if (tx_valid_q && tx_ready) begin
            log_q[n_rx] <= tx_data_q;
            n_rx        <= n_rx + 1;
         end
      end
   end
endmodule // atci_term_model

/* sim/atci_checker.sv */
`timescale 1ns/1ps

module atci_checker #(
   parameter        PW_MAX      = 8,
   parameter [63:0] IDLE_CYCLES = 64'h0000_0000_0000_00C8
) (
   // Clock and reset
   input logic                core_clk,
   input logic                sys_rst,
   // Link
   input logic                rx_valid,
   input logic [7:0]          rx_data,
   input logic                tx_ready,
   input logic                tx_valid_q,
   input logic [7:0]          tx_data_q,
   // Password and dispatch
   input logic [8*PW_MAX-1:0] view_pw,
   input logic [4:0]          view_pw_len,
   input logic                cmd_valid_q,
   input logic [3:0]          cmd_code_q,
   input logic [7:0]          cmd_param_q,
   input logic                logged_in_q
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   logic [63:0] idle_q;
   logic        xoff_q;

   // Idle count restarts on any received byte
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         idle_q <= 64'h0;
         xoff_q <= 1'b0;
      end else begin
         idle_q <= (logged_in_q && !rx_valid) ? idle_q + 64'h1 : 64'h0;
         if (rx_valid && rx_data == 8'h13)
            xoff_q <= 1'b1;
         else if (rx_valid && rx_data == 8'h11)
            xoff_q <= 1'b0;
      end
   end

   sequence s_stall;
      tx_valid_q && !tx_ready;
   endsequence
   sequence s_held;
      tx_valid_q && $stable(tx_data_q);
   endsequence

   a_tx_hold: assert property (s_stall |=> s_held)
      else $error("offered byte lost while stalled");
   a_xoff_quiet: assert property (xoff_q && $past(xoff_q) && !tx_valid_q
      && !(rx_valid && rx_data == 8'h11) |=> !tx_valid_q)
      else $error("byte sent while paused");
   a_plain_out: assert property (tx_valid_q |->
      (tx_data_q >= 8'h20 && tx_data_q <= 8'h7E) || tx_data_q == 8'h0D || tx_data_q == 8'h0A)
      else $error("control byte sent");
   a_cmd_pulse: assert property (cmd_valid_q |=> !cmd_valid_q)
      else $error("dispatch longer than one cycle");
   a_gate_login: assert property (cmd_valid_q |-> $past(logged_in_q))
      else $error("dispatch while logged out");
   a_logout_end: assert property (cmd_valid_q && cmd_code_q == 4'h9 |-> !logged_in_q)
      else $error("logout left session open");
   a_code_range: assert property (cmd_valid_q |-> cmd_code_q <= 4'hA)
      else $error("dispatch code out of range");
   a_param_none: assert property (cmd_valid_q
      && cmd_code_q != 4'h4 && cmd_code_q != 4'h6 |-> cmd_param_q == 8'h00)
      else $error("parameter on plain command");
   a_grp_range: assert property (cmd_valid_q && cmd_code_q == 4'h4
      |-> cmd_param_q >= 8'h01 && cmd_param_q <= 8'h04)
      else $error("group outside range");
   a_idle_limit: assert property (idle_q <= IDLE_CYCLES + 64'h4)
      else $error("idle session not closed");

   cover property ($rose(logged_in_q));
endmodule // atci_checker

/* sim/tb_top.sv */
`timescale 1ns/1ps
`include "atci_defs.vh"

module tb_top;
   localparam        PW_MAX      = 8;
   localparam [63:0] IDLE_CYCLES = 64'h0000_0000_0000_03E8;
   logic        core_clk, sys_rst, rx_valid, tx_ready, tx_valid_q;
   logic        cmd_valid_q, logged_in_q, slow;
   logic [7:0]  rx_data, tx_data_q, cmd_param_q, last_par;
   logic [3:0]  cmd_code_q, last_code;
   logic [63:0] view_pw;
   logic [4:0]  view_pw_len;
   int          bad_count, n_compared, n_cmd, mk;

   atci_core #(.PW_MAX(PW_MAX), .IDLE_CYCLES(IDLE_CYCLES)) dut_u (
      .core_clk(core_clk), .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_data(rx_data),
      .tx_ready(tx_ready), .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q),
      .view_pw(view_pw), .view_pw_len(view_pw_len), .cmd_valid_q(cmd_valid_q),
      .cmd_code_q(cmd_code_q), .cmd_param_q(cmd_param_q), .logged_in_q(logged_in_q));
   atci_term_model term_u (.core_clk(core_clk), .sys_rst(sys_rst), .slow(slow),
      .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q), .tx_ready(tx_ready));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (cmd_valid_q === 1'b1) begin
         n_cmd++;
         last_code <= cmd_code_q;
         last_par  <= cmd_param_q;
      end
   end

   // ==========
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("compared %0d bad %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic snd(input logic [7:0] b);
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_data  <= b;
      @(posedge core_clk);
      rx_valid <= 1'b0;
   endtask
   // No input buffer: wait for a long quiet gap before the next byte
   task automatic settle;
      int q = 0;
      int k = 0;
      while (q < 150) begin
         @(posedge core_clk);
         k++;
         q = (tx_valid_q === 1'b1) ? 0 : q + 1;
         if (k > 5000) begin
            chk(k, 0);
            close_out;
         end
      end
   endtask
   task automatic ln(input string s);
      mk = term_u.n_rx;
      foreach (s[i]) begin
         snd(s[i]);
         settle;
      end
      snd(8'h0D);
      settle;
   endtask
   task automatic txt(input string e);
      chk(term_u.n_rx - mk, e.len());
      foreach (e[i]) chk(term_u.log_q[mk + i], e[i]);
   endtask
   // Odd letters lowered to mix the case
   function automatic string w2s(input logic [55:0] w);
      string s = "";
      for (int i = 6; i >= 0; i--)
         if (w[i*8 +: 8] != 8'h00)
            s = $sformatf("%s%c", s, w[i*8 +: 8] | ((i % 2) ? 8'h20 : 8'h00));
      return s;
   endfunction
   task automatic do_cmd(input logic [55:0] w, input string tail, input logic [3:0] c,
                         input logic [7:0] p);
      int n0 = n_cmd;
      ln({w2s(w), tail});
      chk(n_cmd, n0 + 1);
      chk(last_code, c);
      chk(last_par, p);
   endtask
   task automatic login(input string pw, input string rsp);
      string d = "";
      foreach (pw[i]) d = {d, "."};
      ln("");
      txt("\015\nType login.\015\n");
      ln("LoGiN");
      txt("LoGiN\015\nEnter password.\015\n");
      ln(pw);
      txt({d, "\015\n", rsp, "\015\n"});
   endtask

   // ==========
   // Scenarios
   task automatic t_access;
      ln(w2s(`ATCI_W_STATUS));
      chk(n_cmd, 0);
      login("aB2", "Bad Password.");
      chk(logged_in_q, 1'b0);
      login("ab1", "Logged in.");
      chk(logged_in_q, 1'b1);
      $display("test access done");
   endtask
   task automatic t_edit;
      int hits = 0;
      do_cmd(56'h0, "sta\001tux\177s", `ATCI_C_STATUS, 8'h00);
      txt("statuxs");
      mk = term_u.n_rx;
      snd(8'h13);
      snd("q");
      repeat (60) begin
         @(posedge core_clk);
         if (tx_valid_q !== 1'b0)
            hits++;
      end
      chk(hits, 0);
      snd(8'h11);
      settle;
      txt("q");
      snd(8'h7F);
      settle;
      $display("test edit done");
   endtask
   task automatic t_cmds;
      logic [55:0] wt [7] = '{`ATCI_W_STATUS, `ATCI_W_VALUES, `ATCI_W_MODEL,
         `ATCI_W_EVENTS, `ATCI_W_STNLINE, `ATCI_W_FLTSTAT, `ATCI_W_HELP};
      logic [3:0]  ct [7] = '{`ATCI_C_STATUS, `ATCI_C_VALUES, `ATCI_C_MODEL,
         `ATCI_C_EVENTS, `ATCI_C_STNLINE, `ATCI_C_FLTSTAT, `ATCI_C_HELP};
      slow <= 1'b1;
      foreach (wt[i]) do_cmd(wt[i], "", ct[i], 8'h00);
      do_cmd(`ATCI_W_SETGRP, " 3", `ATCI_C_SETGRP, 8'h03);
      do_cmd(`ATCI_W_FAULT, " 12", `ATCI_C_FAULT, 8'h0C);
      slow <= 1'b0;
      $display("test cmds done");
   endtask
   task automatic t_prompt;
      int n0 = n_cmd;
      ln({w2s(`ATCI_W_SETGRP), " 5"});
      txt({w2s(`ATCI_W_SETGRP), " 5\015\nEnter setting group (1-4) - "});
      chk(n_cmd, n0);
      ln("9");
      txt("9\015\nEnter setting group (1-4) - ");
      do_cmd(56'h0, "4", `ATCI_C_SETGRP, 8'h04);
      ln(w2s(`ATCI_W_FAULT));
      txt({w2s(`ATCI_W_FAULT), "\015\nEnter fault number - "});
      do_cmd(56'h0, "7", `ATCI_C_FAULT, 8'h07);
      ln("bogus");
      txt("bogus\015\nUnknown command, type \"help\" for list of commands.\015\n");
      ln("LOGIN");
      chk(logged_in_q, 1'b0);
      ln("ab1");
      chk(logged_in_q, 1'b1);
      $display("test prompt done");
   endtask
   task automatic t_session;
      int n0;
      do_cmd(`ATCI_W_LOGOUT, "", `ATCI_C_LOGOUT, 8'h00);
      chk(logged_in_q, 1'b0);
      n0 = n_cmd;
      ln(w2s(`ATCI_W_VALUES));
      chk(n_cmd, n0);
      login("AB1", "Logged in.");
      repeat (600) @(posedge core_clk);
      chk(logged_in_q, 1'b1);
      repeat (300) @(posedge core_clk);
      chk(logged_in_q, 1'b0);
      $display("test session done");
   endtask

   initial begin
      sys_rst     = 1'b1;
      rx_valid    = 1'b0;
      rx_data     = 8'h00;
      slow        = 1'b0;
      view_pw     = 64'h0000_0000_0041_6231;
      view_pw_len = 5'h03;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_access;
      t_edit;
      t_cmds;
      t_prompt;
      t_session;
      close_out;
   end
endmodule // tb_top

bind atci_core atci_checker #(.PW_MAX(PW_MAX), .IDLE_CYCLES(IDLE_CYCLES)) chk_u (
   .core_clk(core_clk), .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_data(rx_data),
   .tx_ready(tx_ready), .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q),
   .view_pw(view_pw), .view_pw_len(view_pw_len), .cmd_valid_q(cmd_valid_q),
   .cmd_code_q(cmd_code_q), .cmd_param_q(cmd_param_q), .logged_in_q(logged_in_q));
